//--- common/trip_pkg.sv
// constants, register map and display types of the trip annunciation logic
package trip_pkg;
	localparam int CLK_MHZ       = 250;
	localparam int TICK_US       = 1000;
	localparam int TICK_CYC      = TICK_US * CLK_MHZ;
	localparam int HIGH_LOAD_CODE_TIME_S   = 40;
	localparam int HIGH_LOAD_CODE_TICKS    = HIGH_LOAD_CODE_TIME_S * 1000000 / TICK_US;
	localparam int LTM_CLEAR_MIN = 12;
	localparam int LTM_STEPS     = 16;
	localparam int LTM_FULL      = LTM_CLEAR_MIN * 60 * 1000000 / TICK_US
	                               / LTM_STEPS;
	localparam int HL_NUM        = 17;
	localparam int HL_DEN        = 20;
	localparam int OVER_RANGE_CODE_MULT     = 28;
	localparam int FLASH_BIT     = 8;
	localparam int CUR_W         = 16;
	localparam int CMP_W         = 21;

	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] PICKUP_OFS = 8'h04;
	localparam logic [7:0] PLUG_OFS   = 8'h08;
	localparam logic [7:0] LDTIME_OFS = 8'h0c;
	localparam logic [7:0] STATUS_OFS = 8'h10;
	localparam logic [7:0] LTM_OFS    = 8'h14;

	localparam int CTRL_RRESET_BIT  = 0;
	localparam int CTRL_NEUTRAL_BIT = 1;

	localparam logic [15:0] PICKUP_RST = 16'h03e8;
	localparam logic [15:0] PLUG_RST   = 16'h03e8;
	localparam logic [3:0]  LDTIME_RST = 4'h0;
	localparam logic [1:0]  PH_FIRST   = 2'h0;
	localparam logic [1:0]  PH_LAST    = 2'h3;

	typedef enum logic [2:0] {
		MSG_BLANK, MSG_NUM, MSG_LDT, MSG_INSTANTANEOUS_TRIP_CODE, MSG_HIGH_LOAD_CODE, MSG_LONG_DELAY_PICKUP_CODE, MSG_OVER_RANGE_CODE
	} msg_e;

	typedef enum logic [1:0] {
		VIEW_LIVE, VIEW_HIGH_LOAD_CODE, VIEW_CAUSE, VIEW_CAPT
	} view_e;
endpackage

//--- logic/long_time_memory.sv
// thermal memory accumulator with setting-scaled decay
`timescale 1ns/1ns
module long_time_memory
	import trip_pkg::*;
#(
	parameter int FULL = LTM_FULL
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        tick,
	input  wire logic        heat,
	input  wire logic        trip,
	input  wire logic [3:0]  ld_time,
	output logic      [15:0] level,
	output logic             busy
);
	logic [15:0] level_ff, nxt_level;
	logic [3:0]  div_ff, nxt_div;

	always_comb begin
		nxt_level = level_ff;
		nxt_div   = div_ff;
		if (trip) begin
			nxt_level = 16'(FULL);
			nxt_div   = 4'h0;
		end else if (tick) begin
			if (heat) begin
				if (level_ff < 16'(FULL))
					nxt_level = level_ff + 16'h0001;
				nxt_div = 4'h0;
			end else if (level_ff != 16'h0000) begin
				if (div_ff >= ld_time) begin
					nxt_div   = 4'h0;
					nxt_level = level_ff - 16'h0001;
				end else begin
					nxt_div = div_ff + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			level_ff <= 16'h0000;
			div_ff   <= 4'h0;
		end else begin
			level_ff <= nxt_level;
			div_ff   <= nxt_div;
		end
	end

	assign level = level_ff;
	assign busy  = (level_ff != 16'h0000);
endmodule // long_time_memory

//--- logic/trip_annunciation_logic.sv
// trip cause latching, display, indicators and alarm relays
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ns
// Function
// - long-delay trip lights its LED, shows its code, closes its relay
// - instantaneous trip lights its LED, shows its code, closes its relay
// - each step press advances through phase A, B, C, ground or neutral
// - values shown after a trip are those captured at the trip
// - the LED of the phase being shown is lit
// - trip reset clears messages, stored values, LEDs and all relays
// - thermal memory keeps overload state so a quick reclose trips sooner
// - memory decay grows with delay setting, at most 12 minutes
// - above 0.85 of pickup for 40 s flashes high-load; step clears it
// - same condition closes the high-load relay
// - high-load relay stays closed until local or remote reset
// - long-delay LED flashes while current is above pickup
// - above pickup the pickup message flashes
// - above 28 times plug rating the over-range code replaces the number
// - longer delay setting gives longer memory clearing, in proportion to the setting plus one
module trip_annunciation_logic
	import trip_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC,
	parameter int HIGH_LOAD_CODE_COUNT  = HIGH_LOAD_CODE_TICKS,
	parameter int LTM_COUNT   = LTM_FULL
) (
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             step_btn,
	input  wire logic             trip_reset_btn,
	input  wire logic             ld_trip_evt,
	input  wire logic             instantaneous_trip_code_trip_evt,
	input  wire logic [CUR_W-1:0] cur_a,
	input  wire logic [CUR_W-1:0] cur_b,
	input  wire logic [CUR_W-1:0] cur_c,
	input  wire logic [CUR_W-1:0] cur_gn,
	input  wire logic [7:0]       reg_addr,
	input  wire logic [31:0]      reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic      [31:0]      reg_rdata,
	output msg_e                  disp_msg,
	output logic      [CUR_W-1:0] disp_value,
	output logic                  disp_flash,
	output logic                  led_ld,
	output logic                  led_instantaneous_trip_code,
	output logic      [4:0]       led_phase,
	output logic                  relay_ld,
	output logic                  relay_sc,
	output logic                  relay_hl,
	output logic      [15:0]      ltm_level
);
	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam int HW = $clog2(HIGH_LOAD_CODE_COUNT + 1);

	function automatic logic [CUR_W-1:0] pick(input logic [1:0] i,
		input logic [CUR_W-1:0] a, input logic [CUR_W-1:0] b,
		input logic [CUR_W-1:0] c, input logic [CUR_W-1:0] g);
		case (i)
			2'h0:    pick = a;
			2'h1:    pick = b;
			2'h2:    pick = c;
			default: pick = g;
		endcase
	endfunction

	function automatic logic [CUR_W-1:0] peak(input logic [CUR_W-1:0] a,
		input logic [CUR_W-1:0] b, input logic [CUR_W-1:0] c);
		logic [CUR_W-1:0] m;
		m = (a > b) ? a : b;
		peak = (m > c) ? m : c;
	endfunction

	// registers and read port
	logic [15:0] pickup_ff, nxt_pickup, plug_ff, nxt_plug;
	logic [3:0]  ldtime_ff, nxt_ldtime;
	logic        neutral_ff, nxt_neutral, rreset_ff, nxt_rreset;
	logic [31:0] rdata_ff, nxt_rdata;
	logic        ltm_busy, over_pu, hl_cond, clr;

	always_comb begin
		nxt_pickup  = pickup_ff;
		nxt_plug    = plug_ff;
		nxt_ldtime  = ldtime_ff;
		nxt_neutral = neutral_ff;
		nxt_rreset  = 1'b0;
		nxt_rdata   = 32'h0000_0000;
		if (reg_wr) begin
			case (reg_addr)
				CTRL_OFS: begin
					nxt_rreset  = reg_wdata[CTRL_RRESET_BIT];
					nxt_neutral = reg_wdata[CTRL_NEUTRAL_BIT];
				end
				PICKUP_OFS: nxt_pickup = reg_wdata[15:0];
				PLUG_OFS:   nxt_plug   = reg_wdata[15:0];
				LDTIME_OFS: nxt_ldtime = reg_wdata[3:0];
				default: ;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				CTRL_OFS:   nxt_rdata = {30'h0, neutral_ff, 1'b0};
				PICKUP_OFS: nxt_rdata = {16'h0, pickup_ff};
				PLUG_OFS:   nxt_rdata = {16'h0, plug_ff};
				LDTIME_OFS: nxt_rdata = {28'h0, ldtime_ff};
				STATUS_OFS: nxt_rdata = {25'h0, hl_cond, ltm_busy, over_pu,
					relay_hl, relay_sc, relay_ld, led_instantaneous_trip_code};
				LTM_OFS:    nxt_rdata = {16'h0, ltm_level};
				default:    nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pickup_ff  <= PICKUP_RST;
			plug_ff    <= PLUG_RST;
			ldtime_ff  <= LDTIME_RST;
			neutral_ff <= 1'b0;
			rreset_ff  <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
		end else begin
			pickup_ff  <= nxt_pickup;
			plug_ff    <= nxt_plug;
			ldtime_ff  <= nxt_ldtime;
			neutral_ff <= nxt_neutral;
			rreset_ff  <= nxt_rreset;
			rdata_ff   <= nxt_rdata;
		end
	end
	assign reg_rdata = rdata_ff;

	// millisecond tick, flash phase and high-load timer
	logic [TW-1:0]      tick_ff, nxt_tick;
	logic [FLASH_BIT:0] flash_ff, nxt_flash;
	logic [HW-1:0]      hl_cnt_ff, nxt_hl_cnt;
	logic               tick, flash, hl_done;
	logic [CUR_W-1:0]   live_peak;

	assign clr       = trip_reset_btn | rreset_ff;
	assign live_peak = peak(cur_a, cur_b, cur_c);
	assign over_pu   = live_peak > pickup_ff;
	assign hl_cond   = (CMP_W'(live_peak) * CMP_W'(HL_DEN))
	                 > (CMP_W'(pickup_ff) * CMP_W'(HL_NUM));
	assign tick      = (tick_ff == TW'(TICK_CYCLES - 1));
	assign flash     = flash_ff[FLASH_BIT];
	assign hl_done   = hl_cond && tick && (hl_cnt_ff == HW'(HIGH_LOAD_CODE_COUNT - 1));

	always_comb begin
		nxt_tick   = tick ? '0 : tick_ff + TW'(1);
		nxt_flash  = tick ? flash_ff + 1'b1 : flash_ff;
		nxt_hl_cnt = hl_cnt_ff;
		if (!hl_cond)
			nxt_hl_cnt = '0;
		else if (tick && hl_cnt_ff != HW'(HIGH_LOAD_CODE_COUNT))
			nxt_hl_cnt = hl_cnt_ff + HW'(1);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			tick_ff   <= '0;
			flash_ff  <= '0;
			hl_cnt_ff <= '0;
		end else begin
			tick_ff   <= nxt_tick;
			flash_ff  <= nxt_flash;
			hl_cnt_ff <= nxt_hl_cnt;
		end
	end

	long_time_memory #(
		.FULL    (LTM_COUNT)
	) u_ltm (
		.mclk    (mclk),
		.rst     (rst),
		.tick    (tick),
		.heat    (over_pu),
		.trip    (ld_trip_evt),
		.ld_time (ldtime_ff),
		.level   (ltm_level),
		.busy    (ltm_busy)
	);

	// trip latches, captured currents, view state and relays
	view_e            view_ff, nxt_view;
	logic [1:0]       idx_ff, nxt_idx;
	logic             ldc_ff, nxt_ldc, instc_ff, nxt_instc;
	logic             rld_ff, nxt_rld, rsc_ff, nxt_rsc, rhl_ff, nxt_rhl;
	logic [CUR_W-1:0] cap_ff [4];
	logic [CUR_W-1:0] nxt_cap [4];
	logic             trip;

	assign trip = ld_trip_evt | instantaneous_trip_code_trip_evt;

	always_comb begin
		nxt_view  = view_ff;
		nxt_idx   = idx_ff;
		nxt_ldc   = ldc_ff;
		nxt_instc = instc_ff;
		nxt_rld   = rld_ff;
		nxt_rsc   = rsc_ff;
		nxt_rhl   = rhl_ff;
		nxt_cap   = cap_ff;
		// local or remote reset clears everything
		if (clr) begin
			nxt_view  = VIEW_LIVE;
			nxt_idx   = PH_FIRST;
			nxt_ldc   = 1'b0;
			nxt_instc = 1'b0;
			nxt_rld   = 1'b0;
			nxt_rsc   = 1'b0;
			nxt_rhl   = 1'b0;
			nxt_cap   = '{default: '0};
		end
		if (trip) begin
			nxt_cap   = '{cur_a, cur_b, cur_c, cur_gn};
			nxt_view  = VIEW_CAUSE;
			nxt_idx   = PH_FIRST;
			nxt_ldc   = nxt_ldc | ld_trip_evt;
			nxt_instc = nxt_instc | instantaneous_trip_code_trip_evt;
			nxt_rld   = nxt_rld | ld_trip_evt;
			nxt_rsc   = nxt_rsc | instantaneous_trip_code_trip_evt;
		end else if (step_btn && !clr) begin
			case (view_ff)
				VIEW_CAUSE: begin
					nxt_view = VIEW_CAPT;
					nxt_idx  = PH_FIRST;
				end
				// step leaves the high-load message for live values
				VIEW_HIGH_LOAD_CODE: begin
					nxt_view = VIEW_LIVE;
					nxt_idx  = PH_FIRST;
				end
				// advance and wrap after the last value
				default:   nxt_idx = (idx_ff == PH_LAST) ? PH_FIRST
				                     : idx_ff + 2'h1;
			endcase
		end else if (hl_done && view_ff == VIEW_LIVE) begin
			nxt_view = VIEW_HIGH_LOAD_CODE;
		end
		if (hl_done)
			nxt_rhl = 1'b1;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			view_ff  <= VIEW_LIVE;
			idx_ff   <= PH_FIRST;
			ldc_ff   <= 1'b0;
			instc_ff <= 1'b0;
			rld_ff   <= 1'b0;
			rsc_ff   <= 1'b0;
			rhl_ff   <= 1'b0;
			cap_ff   <= '{default: '0};
		end else begin
			view_ff  <= nxt_view;
			idx_ff   <= nxt_idx;
			ldc_ff   <= nxt_ldc;
			instc_ff <= nxt_instc;
			rld_ff   <= nxt_rld;
			rsc_ff   <= nxt_rsc;
			rhl_ff   <= nxt_rhl;
			cap_ff   <= nxt_cap;
		end
	end

	// display and LED outputs, registered
	msg_e             msg_ff, nxt_msg;
	logic [CUR_W-1:0] val_ff, nxt_val, sel_val;
	logic             dfl_ff, nxt_dfl, lld_ff, nxt_lld, over_range_code_now;
	logic [4:0]       lph_ff, nxt_lph;

	assign sel_val  = (view_ff == VIEW_CAPT)
		? pick(idx_ff, cap_ff[0], cap_ff[1], cap_ff[2], cap_ff[3])
		: pick(idx_ff, cur_a, cur_b, cur_c, cur_gn);
	assign over_range_code_now = CMP_W'(sel_val) > (CMP_W'(plug_ff) * CMP_W'(OVER_RANGE_CODE_MULT));

	always_comb begin
		nxt_msg = MSG_NUM;
		nxt_val = '0;
		nxt_dfl = 1'b0;
		nxt_lph = 5'h00;
		case (view_ff)
			VIEW_CAUSE: nxt_msg = instc_ff ? MSG_INSTANTANEOUS_TRIP_CODE : MSG_LDT;
			VIEW_HIGH_LOAD_CODE: begin
				nxt_msg = MSG_HIGH_LOAD_CODE;
				nxt_dfl = 1'b1;
			end
			default: begin
				// light the LED of the shown phase
				if (idx_ff == PH_LAST)
					nxt_lph = neutral_ff ? 5'h10 : 5'h08;
				else
					nxt_lph = 5'h01 << idx_ff;
				if (over_range_code_now)
					nxt_msg = MSG_OVER_RANGE_CODE;
				else
					nxt_val = sel_val;
				// pickup message flashes over live values
				if (view_ff == VIEW_LIVE && over_pu) begin
					nxt_msg = MSG_LONG_DELAY_PICKUP_CODE;
					nxt_lph = 5'h00;
					nxt_dfl = 1'b1;
				end
			end
		endcase
		// steady after a long-delay trip, flashing above pickup
		nxt_lld = ldc_ff | (over_pu & flash);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			msg_ff <= MSG_BLANK;
			val_ff <= '0;
			dfl_ff <= 1'b0;
			lph_ff <= 5'h00;
			lld_ff <= 1'b0;
		end else begin
			msg_ff <= nxt_msg;
			val_ff <= nxt_val;
			dfl_ff <= nxt_dfl;
			lph_ff <= nxt_lph;
			lld_ff <= nxt_lld;
		end
	end

	assign disp_msg   = msg_ff;
	assign disp_value = val_ff;
	assign disp_flash = dfl_ff & flash;
	assign led_ld     = lld_ff;
	assign led_instantaneous_trip_code   = instc_ff;
	assign led_phase  = lph_ff;
	assign relay_ld   = rld_ff;
	assign relay_sc   = rsc_ff;
	assign relay_hl   = rhl_ff;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_ld_only;
		ld_trip_evt && !instantaneous_trip_code_trip_evt && !instc_ff;
	endsequence
	sequence s_plain_step;
		step_btn && !trip && !clr;
	endsequence

	a_ld_trip_shown: assert property (s_ld_only |=> relay_ld && ldc_ff ##1
		disp_msg == MSG_LDT && led_ld)
		else $error("long-delay trip not annunciated");
	a_instantaneous_trip_code_trip_shown: assert property (instantaneous_trip_code_trip_evt |=> relay_sc &&
		led_instantaneous_trip_code ##1 disp_msg == MSG_INSTANTANEOUS_TRIP_CODE)
		else $error("instantaneous trip not annunciated");
	a_step_advance: assert property (view_ff == VIEW_CAPT &&
		idx_ff != PH_LAST ##0 s_plain_step |=> idx_ff == $past(idx_ff) + 2'h1)
		else $error("step did not advance phase");
	a_step_wrap: assert property (view_ff == VIEW_CAPT &&
		idx_ff == PH_LAST ##0 s_plain_step |=> idx_ff == PH_FIRST)
		else $error("step did not wrap");
	a_capture_trip: assert property (trip |=> cap_ff[0] == $past(cur_a) &&
		cap_ff[3] == $past(cur_gn))
		else $error("currents not captured at trip");
	a_phase_led: assert property (view_ff == VIEW_CAPT &&
		idx_ff == 2'h1 && !trip && !clr |=> led_phase == 5'h02)
		else $error("phase LED wrong");
	a_reset_clears: assert property (clr && !trip && !hl_done |=>
		!relay_ld && !relay_sc && !relay_hl && !led_instantaneous_trip_code ##1
		disp_msg != MSG_LDT && disp_msg != MSG_INSTANTANEOUS_TRIP_CODE)
		else $error("reset did not clear");
	a_hl_relay_set: assert property (hl_done |=> relay_hl)
		else $error("high-load relay not closed");
	a_hl_relay_hold: assert property (relay_hl && !clr |=> relay_hl)
		else $error("high-load relay dropped");
	a_over_range_code_code: assert property (view_ff == VIEW_CAPT && over_range_code_now &&
		!trip && !clr && !step_btn |=> disp_msg == MSG_OVER_RANGE_CODE)
		else $error("over-range code missing");
endmodule // trip_annunciation_logic

//--- bench/panel_operator.sv
// front-panel operator pressing buttons and remote alarm wiring
`timescale 1ns/1ns
module panel_operator (
	input  wire logic mclk,
	input  wire logic relay_ld,
	input  wire logic relay_sc,
	input  wire logic relay_hl,
	output logic      step_btn,
	output logic      trip_reset_btn,
	output logic      alarm_any
);
	initial begin
		step_btn = 1'b0;
		trip_reset_btn = 1'b0;
	end

	task automatic press(input bit rs);
		@(posedge mclk);
		step_btn <= !rs;
		trip_reset_btn <= rs;
		@(posedge mclk);
		step_btn <= 1'b0;
		trip_reset_btn <= 1'b0;
	endtask

	// wiring sees any closed contact
	assign alarm_any = relay_ld | relay_sc | relay_hl;
endmodule // panel_operator

//--- bench/test_trip_annunciation_logic.sv
// self-checking bench of the trip annunciation logic
`timescale 1ns/1ns
module test_trip_annunciation_logic;
	import trip_pkg::*;
	localparam int TK = 4;
	localparam int HC = 5;
	localparam int LC = 10;
	typedef struct {
		string       nm;
		logic [31:0] ex;
		int          sel;
	} note_s;
	note_s            q[$];
	event             sample;
	int               error_cnt = 0;
	int               total_checks = 0;
	int               cyc = 0;
	int               n;
	logic             mclk = 1'b0;
	logic             rst;
	logic             ld_evt;
	logic             instantaneous_trip_code_evt;
	logic [CUR_W-1:0] cur [4];
	logic [CUR_W-1:0] cap [4];
	logic [7:0]       addr;
	logic [31:0]      wdata;
	logic             wr_s;
	logic             rd_s;
	logic [31:0]      reg_rdata;
	msg_e             disp_msg;
	logic [CUR_W-1:0] disp_value;
	logic             disp_flash;
	logic             led_ld;
	logic             led_instantaneous_trip_code;
	logic [4:0]       led_phase;
	logic             relay_ld;
	logic             relay_sc;
	logic             relay_hl;
	logic [15:0]      ltm_level;
	logic             step_btn;
	logic             trip_reset_btn;
	logic             flag;
	logic [3:0]       seen;
	logic             alarm;

	trip_annunciation_logic #(
		.TICK_CYCLES(TK),
		.HIGH_LOAD_CODE_COUNT (HC),
		.LTM_COUNT  (LC)
	) uut (
		.mclk          (mclk),
		.rst           (rst),
		.step_btn      (step_btn),
		.trip_reset_btn(trip_reset_btn),
		.ld_trip_evt   (ld_evt),
		.instantaneous_trip_code_trip_evt (instantaneous_trip_code_evt),
		.cur_a         (cur[0]),
		.cur_b         (cur[1]),
		.cur_c         (cur[2]),
		.cur_gn        (cur[3]),
		.reg_addr      (addr),
		.reg_wdata     (wdata),
		.reg_wr        (wr_s),
		.reg_rd        (rd_s),
		.reg_rdata     (reg_rdata),
		.disp_msg      (disp_msg),
		.disp_value    (disp_value),
		.disp_flash    (disp_flash),
		.led_ld        (led_ld),
		.led_instantaneous_trip_code      (led_instantaneous_trip_code),
		.led_phase     (led_phase),
		.relay_ld      (relay_ld),
		.relay_sc      (relay_sc),
		.relay_hl      (relay_hl),
		.ltm_level     (ltm_level)
	);

	panel_operator op (
		.mclk          (mclk),
		.relay_ld      (relay_ld),
		.relay_sc      (relay_sc),
		.relay_hl      (relay_hl),
		.step_btn      (step_btn),
		.trip_reset_btn(trip_reset_btn),
		.alarm_any     (alarm)
	);

	always #2 mclk = ~mclk;

	function automatic logic [31:0] got(int sel);
		case (sel)
		0: return {29'h0, disp_msg};
		1: return {16'h0, disp_value};
		2: return {27'h0, led_phase};
		3: return {28'h0, relay_hl, relay_sc, relay_ld, led_instantaneous_trip_code};
		4: return reg_rdata;
		5: return {31'h0, led_ld};
		7: return {31'h0, alarm};
		default: return {31'h0, flag};
		endcase
	endfunction

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(int sel, logic [31:0] ex, string nm);
		q.push_back('{nm, ex, sel});
		->sample;
	endtask

	task automatic cy(int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge mclk);
		wr_s <= 1'b0;
	endtask

	task automatic rd(logic [7:0] a, logic [31:0] ex);
		@(posedge mclk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge mclk);
		rd_s <= 1'b0;
		#1;
		chk(4, ex, "rdata");
	endtask

	task automatic setc(int mx);
		@(posedge mclk);
		for (int i = 0; i < 4; i++) begin
			cur[i] <= CUR_W'($urandom_range(mx));
		end
	endtask

	task automatic trip(bit instantaneous_trip_code);
		@(posedge mclk);
		ld_evt <= !instantaneous_trip_code;
		instantaneous_trip_code_evt <= instantaneous_trip_code;
		@(posedge mclk);
		ld_evt <= 1'b0;
		instantaneous_trip_code_evt <= 1'b0;
		#1;
	endtask

	task automatic walk(int k, int over_range_code, int gl);
		for (int i = 0; i < k; i++) begin
			op.press(1'b0);
			cy(2);
			chk(0, (i % 4 == over_range_code) ? MSG_OVER_RANGE_CODE : MSG_NUM, "msg");
			chk(1, (i % 4 == over_range_code) ? 0 : cap[i % 4], "value");
			chk(2, (i % 4 == 3) ? gl : 1 << (i % 4), "phase");
		end
	endtask

	// drains every note whose result has appeared
	initial begin
		note_s m;
		forever begin
			@(sample);
			while (q.size() > 0) begin
				m = q.pop_front();
				total_checks++;
				if (got(m.sel) !== m.ex) begin
					error_cnt++;
					$display("MISMATCH %s exp %h got %h", m.nm, m.ex, got(m.sel));
				end
			end
		end
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 12000) begin
			error_cnt++;
			test_done();
		end
	end

	initial begin
		rst <= 1'b1;
		ld_evt <= 1'b0;
		instantaneous_trip_code_evt <= 1'b0;
		cur <= '{default: '0};
		addr <= 8'h00;
		wdata <= 32'h0;
		wr_s <= 1'b0;
		rd_s <= 1'b0;
		void'($urandom(32'h2307));
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		cy(2);
		chk(0, MSG_NUM, "msg");
		chk(3, 0, "relays");
		rd(PICKUP_OFS, 32'h3e8);
		rd(PLUG_OFS, 32'h3e8);
		rd(LDTIME_OFS, 32'h0);
		wr(STATUS_OFS, 32'hffffffff);
		rd(STATUS_OFS, 32'h0);
		rd(8'h20, 32'h0);
		rd(LTM_OFS, 32'h0);
		$display("test reset done");

		setc(799);
		trip(1'b0);
		cap = cur;
		chk(3, 4'b0010, "relays");
		chk(7, 1, "alarm");
		flag = (ltm_level != 16'h0);
		chk(6, 1, "ltm_held");
		setc(799);
		#1;
		chk(0, MSG_LDT, "msg");
		chk(5, 1, "led_ld");
		walk(5, 9, 8);
		op.press(1'b1);
		cy(1);
		chk(3, 0, "relays");
		cy(1);
		chk(1, cur[0], "value");
		chk(5, 0, "led_ld");
		op.press(1'b0);
		cy(2);
		chk(1, cur[1], "value");
		$display("test long delay trip done");

		wr(CTRL_OFS, 32'h2);
		rd(CTRL_OFS, 32'h2);
		setc(799);
		@(posedge mclk);
		cur[1] <= 16'd30000;
		trip(1'b1);
		cap = cur;
		chk(3, 4'b0101, "relays");
		setc(799);
		#1;
		chk(0, MSG_INSTANTANEOUS_TRIP_CODE, "msg");
		walk(4, 1, 16);
		op.press(1'b1);
		cy(1);
		chk(3, 0, "relays");
		chk(7, 0, "alarm");
		$display("test instantaneous trip done");

		@(posedge mclk);
		cur[0] <= 16'd900;
		n = 0;
		while (relay_hl !== 1'b1 && n < 200) begin
			cy(1);
			n++;
		end
		flag = n >= (HC - 1) * TK && n <= (HC + 1) * TK + 4;
		chk(6, 1, "hl_time");
		cy(2);
		chk(0, MSG_HIGH_LOAD_CODE, "msg");
		op.press(1'b0);
		cy(2);
		chk(1, 900, "value");
		@(posedge mclk);
		cur[0] <= 16'd0;
		cy(50);
		chk(3, 4'b1000, "relays");
		wr(CTRL_OFS, 32'h1);
		cy(2);
		chk(3, 0, "relays");
		$display("test high load done");

		@(posedge mclk);
		cur[0] <= 16'd1200;
		cy(3);
		chk(0, MSG_LONG_DELAY_PICKUP_CODE, "msg");
		seen = 4'h0;
		repeat (2200) begin
			cy(1);
			seen = seen | {led_ld, !led_ld, disp_flash, !disp_flash};
		end
		flag = &seen;
		chk(6, 1, "flashing");
		@(posedge mclk);
		cur[0] <= 16'd0;
		op.press(1'b1);
		$display("test pickup done");

		for (int t = 0; t < 16; t += 15) begin
			wr(LDTIME_OFS, 32'(t));
			trip(1'b0);
			n = 0;
			while (ltm_level !== 16'h0 && n < 1000) begin
				cy(1);
				n++;
			end
			flag = n >= (LC - 1) * (t + 1) * TK - 4
				&& n <= (LC * (t + 1) + 1) * TK + 4;
			chk(6, 1, "ltm_clear");
			op.press(1'b1);
		end
		$display("test thermal memory done");
		cy(2);
		test_done();
	end
endmodule // test_trip_annunciation_logic
